// File: src/csr_pkg.sv
/*
 * csr_pkg: offsets, field layout, reset values, saturation limits and
 * carrier types of the charger setpoint register bank.
 * assumes the register access front end (serial slave) lives elsewhere.
 */
package csr_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    // register offsets
    localparam logic [7:0] OFS_BATT_VOLT = 8'h04;
    localparam logic [7:0] OFS_BOOST_THERM = 8'h05;
    localparam logic [7:0] OFS_IN_FLOOR = 8'h06;
    localparam logic [7:0] OFS_CHG_CURR = 8'h07;

    // field widths
    localparam int unsigned BATT_W = 7;
    localparam int unsigned BOOST_W = 6;
    localparam int unsigned THERM_W = 2;
    localparam int unsigned FLOOR_W = 7;
    localparam int unsigned CURR_W = 6;
    localparam int unsigned TIMER_W = 2;

    // field reset values
    localparam logic [6:0] BATT_RST = 7'h1e;
    localparam logic [5:0] BOOST_RST = 6'h19;
    localparam logic [1:0] THERM_RST = 2'h3;
    localparam logic [6:0] FLOOR_RST = 7'h05;
    localparam logic FLOOR_EN_RST = 1'b1;
    localparam logic [5:0] CURR_RST = 6'h13;
    localparam logic [1:0] TIMER_RST = 2'h0;

    // whole-register reset images
    localparam logic [7:0] BATT_VOLT_RST = 8'h3c;
    localparam logic [7:0] BOOST_THERM_RST = 8'h67;
    localparam logic [7:0] IN_FLOOR_RST = 8'h0b;
    localparam logic [7:0] CHG_CURR_RST = 8'h4c;

    // highest code with a distinct setpoint; codes above clamp to it
    localparam logic [6:0] BATT_MAX = 7'h51;
    localparam logic [5:0] BOOST_MAX = 6'h38;
    localparam logic [6:0] FLOOR_MAX = 7'h5f;
    localparam logic [5:0] CURR_MAX = 6'h31;
    // charge current code of 2.5 A; above it the higher protection level is advised
    localparam logic [5:0] CURR_HIGH_LIMIT = 6'h18;

    // thermal threshold in degrees C and extension time in minutes
    localparam logic [7:0] THERM_DEG_0 = 8'h3c;
    localparam logic [7:0] THERM_DEG_1 = 8'h50;
    localparam logic [7:0] THERM_DEG_2 = 8'h64;
    localparam logic [7:0] THERM_DEG_3 = 8'h78;
    localparam logic [7:0] TIMER_MIN_0 = 8'h00;
    localparam logic [7:0] TIMER_MIN_1 = 8'h1e;
    localparam logic [7:0] TIMER_MIN_2 = 8'h2d;
    localparam logic [7:0] TIMER_MIN_3 = 8'h3c;

    // register access request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } csr_req_t;

    // coded setpoints handed to the analog loops, already saturated
    typedef struct packed {
        logic [BATT_W-1:0] battery_regulation_code;
        logic [BOOST_W-1:0] boost_output_voltage_code;
        logic [THERM_W-1:0] thermal_threshold_code;
        logic [FLOOR_W-1:0] input_voltage_floor_code;
        logic input_floor_loop_enable;
        logic [CURR_W-1:0] charge_current_code;
        logic [TIMER_W-1:0] eoc_extension_code;
    } csr_setpoint_t;
endpackage : csr_pkg

// File: src/csr_setpoint_regs.sv
/*
 * csr_setpoint_regs: four 8-bit setpoint registers of a switching charger
 * (battery voltage, boost voltage and thermal limit, input floor, charge
 * current and end-of-charge extension), with saturated code outputs.
 * assumes a serial slave elsewhere turns bus traffic into one-cycle
 * read/write strobes, and that the global register reset bit is held
 * by its owner until soft_reset_done_o pulses.
 */
`timescale 1ns/1ps

module csr_setpoint_regs (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire csr_pkg::csr_req_t req_i,
    input wire logic soft_reset_i,
    output logic [csr_pkg::DATA_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic addr_hit_o,
    output logic soft_reset_done_o,
    output csr_pkg::csr_setpoint_t setpoint_o,
    output logic [7:0] thermal_threshold_degc_o,
    output logic [7:0] eoc_extension_min_o,
    output logic high_current_hint_o
);
    import csr_pkg::*;

    logic [BATT_W-1:0] batt_q;
    logic [BOOST_W-1:0] boost_q;
    logic [THERM_W-1:0] therm_q;
    logic [FLOOR_W-1:0] floor_q;
    logic floor_en_q;
    logic [CURR_W-1:0] curr_q;
    logic [TIMER_W-1:0] timer_q;
    logic [DATA_W-1:0] rdata_d;
    logic wr_batt;
    logic wr_boost;
    logic wr_floor;
    logic wr_curr;
    logic init;

    // clamp a code to its highest distinct setpoint
    function automatic logic [6:0] sat7(input logic [6:0] code, input logic [6:0] lim);
        sat7 = (code > lim) ? lim : code;
    endfunction : sat7

    function automatic logic [5:0] sat6(input logic [5:0] code, input logic [5:0] lim);
        sat6 = (code > lim) ? lim : code;
    endfunction : sat6

    // hardware reset and the global register reset share one path
    assign init = !rstn_i || soft_reset_i;

    // write decode; writes are dropped while a reset is in force
    assign wr_batt = req_i.wr && (req_i.addr == OFS_BATT_VOLT);
    assign wr_boost = req_i.wr && (req_i.addr == OFS_BOOST_THERM);
    assign wr_floor = req_i.wr && (req_i.addr == OFS_IN_FLOOR);
    assign wr_curr = req_i.wr && (req_i.addr == OFS_CHG_CURR);

    // battery regulation field; bit 0 is reserved and never stored
    always_ff @(posedge mclk_i) begin
        if (init) begin
            batt_q <= BATT_RST;
        end else if (wr_batt) begin
            batt_q <= req_i.wdata[7:1];
        end
    end

    // boost voltage and thermal threshold share one register
    always_ff @(posedge mclk_i) begin
        if (init) begin
            boost_q <= BOOST_RST;
            therm_q <= THERM_RST;
        end else if (wr_boost) begin
            boost_q <= req_i.wdata[7:2];
            therm_q <= req_i.wdata[1:0];
        end
    end

    // input voltage floor code and its loop enable
    always_ff @(posedge mclk_i) begin
        if (init) begin
            floor_q <= FLOOR_RST;
            floor_en_q <= FLOOR_EN_RST;
        end else if (wr_floor) begin
            floor_q <= req_i.wdata[7:1];
            floor_en_q <= req_i.wdata[0];
        end
    end

    // charge current and end-of-charge extension
    always_ff @(posedge mclk_i) begin
        if (init) begin
            curr_q <= CURR_RST;
            timer_q <= TIMER_RST;
        end else if (wr_curr) begin
            curr_q <= req_i.wdata[7:2];
            timer_q <= req_i.wdata[1:0];
        end
    end

    // read mux; raw stored codes are returned, not the saturated ones
    always_comb begin
        rdata_d = '0;
        case (req_i.addr)
            OFS_BATT_VOLT: rdata_d = {batt_q, 1'b0};
            OFS_BOOST_THERM: rdata_d = {boost_q, therm_q};
            OFS_IN_FLOOR: rdata_d = {floor_q, floor_en_q};
            OFS_CHG_CURR: rdata_d = {curr_q, timer_q};
            default: rdata_d = '0;
        endcase
    end

    assign addr_hit_o = (req_i.addr >= OFS_BATT_VOLT) && (req_i.addr <= OFS_CHG_CURR);

    // read data lands one cycle after the strobe and holds until the next read
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= rdata_d;
            end
        end
    end

    // done pulse tells the reset bit owner to clear it; one cycle suffices
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            soft_reset_done_o <= 1'b0;
        end else begin
            soft_reset_done_o <= soft_reset_i && !soft_reset_done_o;
        end
    end

    // saturated codes; the loops never see a code past the top setpoint
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            setpoint_o <= '{BATT_RST, BOOST_RST, THERM_RST, FLOOR_RST, FLOOR_EN_RST,
                            CURR_RST, TIMER_RST};
        end else begin
            setpoint_o.battery_regulation_code <= sat7(batt_q, BATT_MAX);
            setpoint_o.boost_output_voltage_code <= sat6(boost_q, BOOST_MAX);
            setpoint_o.thermal_threshold_code <= therm_q;
            setpoint_o.input_voltage_floor_code <= sat7(floor_q, FLOOR_MAX);
            setpoint_o.input_floor_loop_enable <= floor_en_q;
            setpoint_o.charge_current_code <= sat6(curr_q, CURR_MAX);
            setpoint_o.eoc_extension_code <= timer_q;
        end
    end

    // decoded thermal threshold and extension time
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            thermal_threshold_degc_o <= THERM_DEG_3;
            eoc_extension_min_o <= TIMER_MIN_0;
        end else begin
            case (therm_q)
                2'h0: thermal_threshold_degc_o <= THERM_DEG_0;
                2'h1: thermal_threshold_degc_o <= THERM_DEG_1;
                2'h2: thermal_threshold_degc_o <= THERM_DEG_2;
                default: thermal_threshold_degc_o <= THERM_DEG_3;
            endcase
            case (timer_q)
                2'h0: eoc_extension_min_o <= TIMER_MIN_0;
                2'h1: eoc_extension_min_o <= TIMER_MIN_1;
                2'h2: eoc_extension_min_o <= TIMER_MIN_2;
                default: eoc_extension_min_o <= TIMER_MIN_3;
            endcase
        end
    end

    // advisory only: the protection bit lives elsewhere and the host sets it
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            high_current_hint_o <= 1'b0;
        end else begin
            high_current_hint_o <= (curr_q > CURR_HIGH_LIMIT);
        end
    end

    // checks on fields, decode and read port
    sequence write_to(logic [7:0] ofs);
        req_i.wr && !soft_reset_i && (req_i.addr == ofs);
    endsequence

    sequence read_of(logic [7:0] ofs);
        req_i.rd && !req_i.wr && !soft_reset_i && (req_i.addr == ofs);
    endsequence

    batt_reset_val_a: assert property (@(posedge mclk_i)
        !rstn_i |=> batt_q == BATT_RST && {batt_q, 1'b0} == BATT_VOLT_RST)
        else $error("battery code reset value wrong");

    boost_reset_val_a: assert property (@(posedge mclk_i)
        !rstn_i |=> {boost_q, therm_q} == BOOST_THERM_RST)
        else $error("boost register reset value wrong");

    floor_reset_val_a: assert property (@(posedge mclk_i)
        soft_reset_i |=> {floor_q, floor_en_q} == IN_FLOOR_RST)
        else $error("input floor register reset value wrong");

    curr_reset_val_a: assert property (@(posedge mclk_i)
        soft_reset_i |=> {curr_q, timer_q} == CHG_CURR_RST)
        else $error("charge current register reset value wrong");

    batt_readback_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        write_to(OFS_BATT_VOLT) ##1 read_of(OFS_BATT_VOLT)
        |=> rdata_o == {$past(req_i.wdata[7:1], 2), 1'b0})
        else $error("battery register readback wrong");

    curr_readback_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        write_to(OFS_CHG_CURR) ##1 read_of(OFS_CHG_CURR) |=> rdata_o == $past(req_i.wdata, 2))
        else $error("charge current readback wrong");

    batt_sat_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        batt_q > BATT_MAX |=> setpoint_o.battery_regulation_code == BATT_MAX)
        else $error("battery code not saturated");

    boost_sat_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        boost_q > BOOST_MAX |=> setpoint_o.boost_output_voltage_code == BOOST_MAX)
        else $error("boost code saturation wrong");

    boost_pass_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        boost_q <= BOOST_MAX |=> setpoint_o.boost_output_voltage_code == $past(boost_q))
        else $error("boost code not passed through");

    floor_sat_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(floor_q > FLOOR_MAX) |=> setpoint_o.input_voltage_floor_code == FLOOR_MAX)
        else $error("input floor code not saturated");

    therm_decode_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        therm_q == 2'h0 |=> thermal_threshold_degc_o == THERM_DEG_0)
        else $error("thermal threshold decode wrong");

    soft_done_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(soft_reset_i) |=> soft_reset_done_o ##1 !soft_reset_done_o)
        else $error("soft reset done pulse wrong");

    hint_at_limit_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        curr_q == CURR_HIGH_LIMIT |=> !high_current_hint_o)
        else $error("high current hint at 2.5 A");

    // remaining decode points, current saturation, pass-through codes and read port behaviour
    hint_above_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        curr_q > CURR_HIGH_LIMIT |=> high_current_hint_o)
        else $error("high current hint missing");

    therm_eighty_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        therm_q == 2'h1 |=> thermal_threshold_degc_o == THERM_DEG_1)
        else $error("thermal threshold decode wrong for code 1");

    therm_hundred_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        therm_q == 2'h2 |=> thermal_threshold_degc_o == THERM_DEG_2)
        else $error("thermal threshold decode wrong for code 2");

    therm_top_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        therm_q == 2'h3 |=> thermal_threshold_degc_o == THERM_DEG_3)
        else $error("thermal threshold decode wrong for code 3");

    timer_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        timer_q == 2'h0 |=> eoc_extension_min_o == TIMER_MIN_0)
        else $error("extension time decode wrong for code 0");

    timer_thirty_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        timer_q == 2'h1 |=> eoc_extension_min_o == TIMER_MIN_1)
        else $error("extension time decode wrong for code 1");

    timer_mid_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        timer_q == 2'h2 |=> eoc_extension_min_o == TIMER_MIN_2)
        else $error("extension time decode wrong for code 2");

    timer_top_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        timer_q == 2'h3 |=> eoc_extension_min_o == TIMER_MIN_3)
        else $error("extension time decode wrong for code 3");

    curr_sat_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        curr_q > CURR_MAX |=> setpoint_o.charge_current_code == CURR_MAX)
        else $error("charge current code not saturated");

    batt_pass_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        batt_q <= BATT_MAX |=> setpoint_o.battery_regulation_code == $past(batt_q))
        else $error("battery code not passed through");

    floor_en_on_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        floor_en_q |=> setpoint_o.input_floor_loop_enable)
        else $error("input floor loop not enabled");

    floor_en_off_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !floor_en_q |=> !setpoint_o.input_floor_loop_enable)
        else $error("input floor loop not disabled");

    rvalid_pulse_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.rd |=> rvalid_o)
        else $error("read valid missing after read strobe");

    rvalid_idle_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !req_i.rd |=> !rvalid_o)
        else $error("read valid without read strobe");

    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.rd && (req_i.addr == OFS_BATT_VOLT) |=> !rdata_o[0])
        else $error("reserved battery bit reads one");

    unmapped_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.rd && (req_i.addr < OFS_BATT_VOLT || req_i.addr > OFS_CHG_CURR)
        |=> rdata_o == '0)
        else $error("unmapped read not zero");
endmodule : csr_setpoint_regs

// File: verif/csr_host_model.sv
/*
 * csr_host_model: host side of the setpoint bank, owner of the global
 * register reset bit and of the overcurrent protection level bit.
 * assumes the bench calls global_reset() and drives nothing else here.
 */
`timescale 1ns/1ps
module csr_host_model (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic soft_reset_done_i,
    input wire logic high_current_hint_i,
    output logic soft_reset_o,
    output logic ocp_level_o
);
    // protection level follows the advisory hint, one cycle late
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ocp_level_o <= 1'b0;
        end else begin
            ocp_level_o <= high_current_hint_i;
        end
    end

    initial begin
        soft_reset_o = 1'b0;
    end

    // bit held until the bank reports done; bounded so a dead bank cannot hang us
    task automatic global_reset(output logic ok);
        ok = 1'b0;
        @(negedge mclk_i);
        soft_reset_o = 1'b1;
        repeat (8) begin
            @(negedge mclk_i);
            if (soft_reset_done_i === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        soft_reset_o = 1'b0;
    endtask : global_reset
endmodule : csr_host_model

// File: verif/charger_setpoint_registers_bench.sv
/*
 * charger_setpoint_registers_bench: register-level tests of the setpoint bank.
 * assumes the strobe port of the bank and the host model beside it.
 */
`timescale 1ns/1ps
module charger_setpoint_registers_bench;
    import csr_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic soft_reset_i;
    csr_req_t req_i = '0;
    logic [7:0] rdata_o;
    logic [7:0] degc;
    logic [7:0] mins;
    logic rvalid_o;
    logic addr_hit_o;
    logic done;
    logic hint;
    logic overcurrent_protection_level;
    logic ok;
    csr_setpoint_t sp;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] degc_tab [4] = '{8'h3c, 8'h50, 8'h64, 8'h78};
    logic [7:0] min_tab [4] = '{8'h00, 8'h1e, 8'h2d, 8'h3c};

    // 200 MHz clock
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    csr_setpoint_regs i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req_i), .soft_reset_i(soft_reset_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .addr_hit_o(addr_hit_o),
        .soft_reset_done_o(done), .setpoint_o(sp), .thermal_threshold_degc_o(degc),
        .eoc_extension_min_o(mins), .high_current_hint_o(hint)
    );

    csr_host_model i_host (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .soft_reset_done_i(done),
        .high_current_hint_i(hint), .soft_reset_o(soft_reset_i), .ocp_level_o(overcurrent_protection_level)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // one-cycle write strobe, launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        req_i.wr = 1'b1;
        req_i.addr = a;
        req_i.wdata = d;
        @(negedge mclk_i);
        req_i.wr = 1'b0;
    endtask : wr

    // read strobe; data and valid are looked at in the cycle they stand
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        req_i.rd = 1'b1;
        req_i.addr = a;
        #1 check({7'h00, addr_hit_o}, {7'h00, (a >= 8'h04 && a <= 8'h07)}, "hit");
        @(negedge mclk_i);
        req_i.rd = 1'b0;
        check({7'h00, rvalid_o}, 8'h01, "rvalid");
        check(rdata_o, exp, "rdata");
    endtask : rd

    // write strobe followed at once by a read strobe of the same place
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(negedge mclk_i);
        req_i.wr = 1'b1;
        req_i.addr = a;
        req_i.wdata = d;
        @(negedge mclk_i);
        req_i.wr = 1'b0;
        req_i.rd = 1'b1;
        @(negedge mclk_i);
        req_i.rd = 1'b0;
        check({7'h00, rvalid_o}, 8'h01, "rvalid");
        check(rdata_o, exp, "rdata");
    endtask : wr_rd

    // whole-register images and decoded outputs after either reset
    task automatic chk_defaults();
        rd(8'h04, 8'h3c);
        rd(8'h05, 8'h67);
        rd(8'h06, 8'h0b);
        rd(8'h07, 8'h4c);
        check({1'b0, sp.battery_regulation_code}, 8'h1e, "batt");
        check({2'b0, sp.boost_output_voltage_code}, 8'h19, "boost");
        check(degc, 8'h78, "degc");
        check({1'b0, sp.input_voltage_floor_code}, 8'h05, "floor");
        check({7'h0, sp.input_floor_loop_enable}, 8'h01, "en");
        check({2'b0, sp.charge_current_code}, 8'h13, "curr");
        check(mins, 8'h00, "mins");
    endtask : chk_defaults

    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            $display("BAD %0t timeout", $time);
            finish_test();
        end
    end

    initial begin
        repeat (16) @(negedge mclk_i);
        rstn_i = 1'b1;
        chk_defaults();
        // back-to-back write and read; reserved bit dropped
        wr_rd(8'h04, 8'h3b, 8'h3a);
        wr_rd(8'h07, 8'h4d, 8'h4d);
        // top code clamps; reserved bit reads back zero
        wr(8'h04, 8'hff);
        rd(8'h04, 8'hfe);
        check({1'b0, sp.battery_regulation_code}, 8'h51, "batt sat");
        wr(8'h04, 8'ha0);
        rd(8'h04, 8'ha0);
        check({1'b0, sp.battery_regulation_code}, 8'h50, "batt");
        for (int i = 0; i < 4; i++) begin
            wr(8'h05, {6'h39, i[1:0]});
            rd(8'h05, {6'h39, i[1:0]});
            check({2'b0, sp.boost_output_voltage_code}, 8'h38, "boost sat");
            check(degc, degc_tab[i], "degc");
            wr(8'h07, {6'h32, i[1:0]});
            rd(8'h07, {6'h32, i[1:0]});
            check({2'b0, sp.charge_current_code}, 8'h31, "curr sat");
            check(mins, min_tab[i], "mins");
            check({7'h0, hint}, 8'h01, "hint");
            check({7'h0, overcurrent_protection_level}, 8'h01, "ocp level");
        end
        wr(8'h06, 8'hc0);
        rd(8'h06, 8'hc0);
        check({1'b0, sp.input_voltage_floor_code}, 8'h5f, "floor sat");
        check({7'h0, sp.input_floor_loop_enable}, 8'h00, "en off");
        wr(8'h07, 8'h60);
        rd(8'h07, 8'h60);
        check({7'h0, hint}, 8'h00, "hint at limit");
        check({7'h0, overcurrent_protection_level}, 8'h00, "ocp low");
        check({2'b0, sp.charge_current_code}, 8'h18, "curr");
        // unmapped places read zero and take no write
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h00);
        rd(8'h03, 8'h00);
        i_host.global_reset(ok);
        check({7'h0, ok}, 8'h01, "done");
        repeat (2) @(negedge mclk_i);
        chk_defaults();
        finish_test();
    end
endmodule : charger_setpoint_registers_bench
